// [rcs_top.sv]
// reference clock output selector: two output sides with Avalon-MM registers
// assumes recovered and external clocks are synchronous samples at I_CLK
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/100ps

module rcs_side #(
  parameter int WIN = rcs_pkg::WIN_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire rcs_pkg::rcs_cfg_t i_cfg,
  input wire logic [rcs_pkg::NUM_CH-1:0] i_recov,
  input wire logic i_ext,
  input wire logic i_win,
  output logic o_ref,
  output logic o_fault
);
  import rcs_pkg::*;
  localparam int EXP_T1 = T1_KHZ * WIN / CLK_KHZ;
  localparam int EXP_E1 = E1_KHZ * WIN / CLK_KHZ;
  localparam int TOL_T1 = EXP_T1 / 32 + 1;
  localparam int TOL_E1 = EXP_E1 / 32 + 1;

  logic ext_prev_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic sel_clk;
  logic in_range;
  int cnt_i;

  always_comb begin
    if (i_cfg.sel <= SEL_LAST_CH) begin
      sel_clk = i_recov[i_cfg.sel];
    end else begin
      sel_clk = i_ext;
    end
  end

  // retimed so the pin comes from a flop; costs one cycle of skew
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_ref <= 1'b0;
    end else begin
      o_ref <= sel_clk;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= i_ext;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cnt_reg <= '0;
    end else if (i_win) begin
      cnt_reg <= {{(CNT_W-1){1'b0}}, i_ext & ~ext_prev_reg};
    end else if (i_ext & ~ext_prev_reg & ~&cnt_reg) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // rate flag picks the nominal edge count per window
  always_comb begin
    cnt_i = int'(cnt_reg);
    if (i_cfg.e1) begin
      in_range = (cnt_i >= EXP_E1 - TOL_E1) && (cnt_i <= EXP_E1 + TOL_E1);
    end else begin
      in_range = (cnt_i >= EXP_T1 - TOL_T1) && (cnt_i <= EXP_T1 + TOL_T1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_fault <= 1'b0;
    end else if (i_win) begin
      o_fault <= ~in_range;
    end
  end

  rate_check_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_win |=> o_fault == !$past(in_range)) else $error("rate fault not taken from window count");
  mux_follow_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !i_reset |=> o_ref == $past(i_cfg.sel <= SEL_LAST_CH ? i_recov[i_cfg.sel] : i_ext))
    else $error("reference output does not follow selected source");
  // fault only moves at a window end, so software reads a settled value
  fault_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !i_win |=> $stable(o_fault))
    else $error("rate fault changed between windows");
  count_restart_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_win |=> cnt_reg[CNT_W-1:1] == '0)
    else $error("edge count not restarted at window end");
  recov_sel_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_cfg.sel <= SEL_LAST_CH |=> o_ref == $past(i_recov[i_cfg.sel]))
    else $error("reference output not on selected channel");
endmodule // rcs_side

module rcs_top #(
  parameter int WIN_CYCLES = rcs_pkg::WIN_CYCLES
) (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RESET,
  // avalon-mm slave
  input wire logic [9:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  // clock sources
  input wire logic [rcs_pkg::NUM_CH-1:0] I_RECOV_CLK,
  input wire logic I_EXT_CLK_A,
  input wire logic I_EXT_CLK_B,
  // reference output pins
  output logic O_REF_A,
  output logic O_REF_A_OE,
  output logic O_REF_B,
  output logic O_REF_B_OE
);
  import rcs_pkg::*;
  localparam int WW = $clog2(WIN_CYCLES + 1);

  rcs_req_t req;
  rcs_cfg_t cfg_a_reg;
  rcs_cfg_t cfg_b_reg;
  logic waitreq_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [WW-1:0] win_cnt_reg;
  logic win_reg;
  logic fault_a;
  logic fault_b;
  logic req_on;
  logic wr_go;

  assign req = '{rd: I_AVS_READ, wr: I_AVS_WRITE, addr: I_AVS_ADDRESS,
                 wdata: I_AVS_WRITEDATA[7:0], be0: I_AVS_BYTEENABLE[0]};
  assign req_on = req.rd | req.wr;
  // write lands on the edge where the master sees waitrequest low
  assign wr_go = req.wr & ~waitreq_reg & req.be0;

  // one wait state for every access
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      waitreq_reg <= 1'b1;
    end else begin
      waitreq_reg <= ~(req_on & waitreq_reg);
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      cfg_a_reg <= CFG_RST;
    end else if (wr_go && req.addr == REF_A_OFS) begin
      cfg_a_reg <= req.wdata[6:0];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      cfg_b_reg <= CFG_RST;
    end else if (wr_go && req.addr == REF_B_OFS) begin
      cfg_b_reg <= req.wdata[6:0];
    end
  end

  // unmapped addresses read zero
  always_comb begin
    rdata_next = 32'h0;
    case (req.addr)
      REF_A_OFS: rdata_next = {25'h0, cfg_a_reg};
      REF_B_OFS: rdata_next = {25'h0, cfg_b_reg};
      // status: external selection flags above the two rate faults
      STATUS_OFS: begin
        rdata_next = {28'h0, cfg_b_reg.sel > SEL_LAST_CH, cfg_a_reg.sel > SEL_LAST_CH, fault_b, fault_a};
      end
      default: rdata_next = 32'h0;
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      rdata_reg <= 32'h0;
    end else if (req.rd & waitreq_reg) begin
      rdata_reg <= rdata_next;
    end
  end

  // measurement window divider
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      win_cnt_reg <= '0;
      win_reg <= 1'b0;
    end else if (win_cnt_reg == WW'(WIN_CYCLES - 1)) begin
      win_cnt_reg <= '0;
      win_reg <= 1'b1;
    end else begin
      win_cnt_reg <= win_cnt_reg + 1'b1;
      win_reg <= 1'b0;
    end
  end

  // both sides share one window so their faults update together
  rcs_side #(.WIN(WIN_CYCLES)) u_side_a (
    .i_clk(I_CLK),
    .i_reset(I_RESET),
    .i_cfg(cfg_a_reg),
    .i_recov(I_RECOV_CLK),
    .i_ext(I_EXT_CLK_A),
    .i_win(win_reg),
    .o_ref(O_REF_A),
    .o_fault(fault_a)
  );

  rcs_side #(.WIN(WIN_CYCLES)) u_side_b (
    .i_clk(I_CLK),
    .i_reset(I_RESET),
    .i_cfg(cfg_b_reg),
    .i_recov(I_RECOV_CLK),
    .i_ext(I_EXT_CLK_B),
    .i_win(win_reg),
    .o_ref(O_REF_B),
    .o_fault(fault_b)
  );

  assign O_REF_A_OE = cfg_a_reg.oe;
  assign O_REF_B_OE = cfg_b_reg.oe;
  assign O_AVS_READDATA = rdata_reg;
  assign O_AVS_WAITREQUEST = waitreq_reg;

  oe_a_write_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    wr_go && req.addr == REF_A_OFS |=> O_REF_A_OE == $past(I_AVS_WRITEDATA[6]))
    else $error("output A enable not taken from write");
  oe_b_write_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    wr_go && req.addr == REF_B_OFS |=> O_REF_B_OE == $past(I_AVS_WRITEDATA[6]))
    else $error("output B enable not taken from write");
  rate_a_write_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    wr_go && req.addr == REF_A_OFS |=> cfg_a_reg.e1 == $past(I_AVS_WRITEDATA[5]))
    else $error("input A rate flag not taken from write");
  rate_b_write_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    wr_go && req.addr == REF_B_OFS |=> cfg_b_reg.e1 == $past(I_AVS_WRITEDATA[5]))
    else $error("input B rate flag not taken from write");
  reset_value_a: assert property (@(posedge I_CLK)
    I_RESET |=> cfg_a_reg == CFG_RST && cfg_b_reg == CFG_RST && O_REF_A_OE && O_REF_B_OE)
    else $error("configuration not at reset value");
  b_readback_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    req.rd && waitreq_reg && req.addr == REF_B_OFS |=> O_AVS_READDATA == {25'h0, $past(cfg_b_reg)})
    else $error("side B register readback wrong");
  reserved_zero_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    req.rd && !waitreq_reg |-> O_AVS_READDATA[31:7] == 25'h0)
    else $error("reserved bits not zero");
  one_wait_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    req_on && waitreq_reg |=> !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST)
    else $error("wait request not one cycle");
  sel_b_ext_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    cfg_b_reg.sel > SEL_LAST_CH && $stable(cfg_b_reg) |=> O_REF_B == $past(I_EXT_CLK_B))
    else $error("output B not on external input");

  // selection, strobes, readback, wait request, window pulse and enable hold
  sel_a_ext_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    cfg_a_reg.sel > SEL_LAST_CH && $stable(cfg_a_reg) |=> O_REF_A == $past(I_EXT_CLK_A))
    else $error("output A not on external input");
  sel_a_write_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    wr_go && req.addr == REF_A_OFS |=> cfg_a_reg.sel == $past(I_AVS_WRITEDATA[4:0]))
    else $error("source select A not taken from write");
  sel_b_write_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    wr_go && req.addr == REF_B_OFS |=> cfg_b_reg.sel == $past(I_AVS_WRITEDATA[4:0]))
    else $error("source select B not taken from write");
  // a write without byte 0 must leave both registers untouched
  strobe_ignore_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    req.wr && !req.be0 |=> $stable(cfg_a_reg) && $stable(cfg_b_reg))
    else $error("write without byte enable changed a register");
  a_readback_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    req.rd && waitreq_reg && req.addr == REF_A_OFS |=> O_AVS_READDATA == {25'h0, $past(cfg_a_reg)})
    else $error("side A register readback wrong");
  unmapped_zero_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    req.rd && waitreq_reg && req.addr != REF_A_OFS && req.addr != REF_B_OFS && req.addr != STATUS_OFS
      |=> O_AVS_READDATA == 32'h0)
    else $error("unmapped address did not read zero");
  status_ext_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    req.rd && waitreq_reg && req.addr == STATUS_OFS |=> O_AVS_READDATA[3:2] == {$past(cfg_b_reg.sel > SEL_LAST_CH), $past(cfg_a_reg.sel > SEL_LAST_CH)})
    else $error("status external flags wrong");
  status_fault_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    req.rd && waitreq_reg && req.addr == STATUS_OFS |=> O_AVS_READDATA[1:0] == $past({fault_b, fault_a}))
    else $error("status rate faults wrong");
  wait_idle_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    !req_on |=> O_AVS_WAITREQUEST)
    else $error("wait request low while idle");
  win_pulse_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    win_reg |=> !win_reg)
    else $error("window enable longer than one cycle");
  oe_hold_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    !wr_go |=> $stable(O_REF_A_OE) && $stable(O_REF_B_OE))
    else $error("output enable changed without a write");

  ext_a_c: cover property (@(posedge I_CLK) disable iff (I_RESET) cfg_a_reg.sel == 5'h1F);
  hiz_b_c: cover property (@(posedge I_CLK) disable iff (I_RESET) !O_REF_B_OE);
  e1_fault_c: cover property (@(posedge I_CLK) disable iff (I_RESET) cfg_a_reg.e1 && win_reg);
  st_read_c: cover property (@(posedge I_CLK) disable iff (I_RESET) req.rd && req.addr == STATUS_OFS && !waitreq_reg);
  fault_b_c: cover property (@(posedge I_CLK) disable iff (I_RESET) fault_b);
endmodule // rcs_top

// [rcs_pkg.sv]
// constants and types for the reference clock output selector
// assumes a single 25 MHz system clock and a synchronous active-high reset
//
// What this block does
// - side A enable bit 6 low puts output A in high-Z; reset value 1.
// - side A bit 5 gives external input A rate: 0 T1, 1 E1; reset 0.
// - side A select 0..28 picks recovered channel clock, 29..31 external input; reset 1.
// - side B enable bit 6 low puts output B in high-Z; reset value 1.
// - side B bit 5 gives external input B rate: 0 T1, 1 E1; reset 0.
// - side B select 0..28 picks recovered channel clock, 29..31 external input; reset 1.
// - T1 rate means 1.544 MHz, E1 rate means 2.048 MHz.
package rcs_pkg;
  localparam logic [9:0] REF_A_OFS = 10'h240;
  localparam logic [9:0] REF_B_OFS = 10'h280;
  localparam logic [9:0] STATUS_OFS = 10'h2A0;
  localparam logic [6:0] CFG_RST = 7'h41;
  localparam logic [4:0] SEL_LAST_CH = 5'h1C;
  localparam int NUM_CH = 29;
  localparam int CLK_KHZ = 25000;
  localparam int T1_KHZ = 1544;
  localparam int E1_KHZ = 2048;
  localparam int WIN_US = 1000;
  localparam int WIN_CYCLES = CLK_KHZ * WIN_US / 1000;
  localparam int CNT_W = 16;

  typedef struct packed {
    logic oe;
    logic e1;
    logic [4:0] sel;
  } rcs_cfg_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [9:0] addr;
    logic [7:0] wdata;
    logic be0;
  } rcs_req_t;
endpackage

// [rcs_clk_src.sv]
// far-side clock sources: recovered channel clocks and two external inputs
// assumes it shares the bench clock; all lines change just after its edge
`timescale 1ns/100ps
module rcs_clk_src import rcs_pkg::*; #(
  parameter int KHZ_A = T1_KHZ,
  parameter int KHZ_B = E1_KHZ
) (
  // clock
  input wire logic i_clk,
  // sources
  output logic [28:0] o_recov,
  output logic o_ext_a,
  output logic o_ext_b
);
  logic [28:0] lfsr = 29'h0;
  logic ea = 1'b0;
  logic eb = 1'b0;
  int acc_a = 0;
  int acc_b = 0;
  assign o_recov = lfsr;
  assign o_ext_a = ea;
  assign o_ext_b = eb;
  // pseudo-random channels so every channel select code 0..28 shows a distinct pattern
  always @(posedge i_clk) begin
    lfsr <= {lfsr[27:0], ~(lfsr[28] ^ lfsr[26])};
  end
  // phase accumulators: edge rate exact on average, jitter of one cycle
  always @(posedge i_clk) begin
    acc_a <= (acc_a + 2 * KHZ_A) % CLK_KHZ;
    acc_b <= (acc_b + 2 * KHZ_B) % CLK_KHZ;
    if (acc_a + 2 * KHZ_A >= CLK_KHZ) ea <= ~ea;
    if (acc_b + 2 * KHZ_B >= CLK_KHZ) eb <= ~eb;
  end
endmodule // rcs_clk_src

// [test_reference_clock_output_selector.sv]
// self-checking bench for the reference clock output selector
// assumes rcs_pkg, rcs_top and rcs_clk_src are compiled before it
`timescale 1ns/100ps
module test_reference_clock_output_selector;
  import rcs_pkg::*;
  logic I_CLK = 0, I_RESET = 1, I_AVS_READ = 0, I_AVS_WRITE = 0, go = 0;
  logic [9:0] I_AVS_ADDRESS = 10'h000;
  logic [31:0] I_AVS_WRITEDATA = 32'h0;
  logic [3:0] I_AVS_BYTEENABLE = 4'hF;
  logic [31:0] O_AVS_READDATA;
  logic O_AVS_WAITREQUEST, O_REF_A, O_REF_A_OE, O_REF_B, O_REF_B_OE, ext_a, ext_b;
  logic [28:0] recov;
  int seed = 94628, n_errors = 0, total_checks = 0, cyc = 0;
  int cfg_a = 'h41, cfg_b = 'h41, exp_a = 0, exp_b = 0;
  int fa = 0, fb = 0, st_exp = 0, wc = 0, wp = 0;
  localparam int WIN = 2500;
  always #20 I_CLK = ~I_CLK;
  rcs_top #(.WIN_CYCLES(WIN)) rcs_top_i (.I_CLK(I_CLK), .I_RESET(I_RESET), .I_AVS_ADDRESS(I_AVS_ADDRESS),
    .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA),
    .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE), .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
    .I_RECOV_CLK(recov), .I_EXT_CLK_A(ext_a), .I_EXT_CLK_B(ext_b), .O_REF_A(O_REF_A),
    .O_REF_A_OE(O_REF_A_OE), .O_REF_B(O_REF_B), .O_REF_B_OE(O_REF_B_OE));
  rcs_clk_src #(.KHZ_A(T1_KHZ), .KHZ_B(E1_KHZ)) rcs_clk_src_i (.i_clk(I_CLK), .o_recov(recov), .o_ext_a(ext_a),
    .o_ext_b(ext_b));
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: pin got %h expected %h", $time, got, exp);
    end
  endtask
  // a flag naming the wrong rate for the input must raise the fault
  function automatic int rate_bad(int c, int khz);
    return ((((c >> 5) & 1) != 0) ? E1_KHZ : T1_KHZ) != khz;
  endfunction
  function automatic int src(int c, logic [28:0] r, logic e);
    return (c & 31) < NUM_CH ? int'(r[c & 31]) : int'(e);
  endfunction
  // one request held until waitrequest is seen low; reads checked at that edge
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [3:0] be);
    int e;
    @(posedge I_CLK);
    I_AVS_WRITE <= w;
    I_AVS_READ <= !w;
    I_AVS_ADDRESS <= a;
    I_AVS_WRITEDATA <= {24'($random(seed)), d};
    I_AVS_BYTEENABLE <= be;
    do begin
      @(posedge I_CLK);
    end while (O_AVS_WAITREQUEST !== 1'b0);
    e = a == REF_A_OFS ? cfg_a : a == REF_B_OFS ? cfg_b : a == STATUS_OFS ? st_exp : 0;
    if (!w) chk(O_AVS_READDATA, e);
    I_AVS_WRITE <= 1'b0;
    I_AVS_READ <= 1'b0;
  endtask
  always @(posedge I_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      summarize;
    end
  end
  // reference model: config registers and one-cycle retimed source
  always @(posedge I_CLK) begin
    if (I_RESET) begin
      cfg_a <= 'h41;
      cfg_b <= 'h41;
      exp_a <= 0;
      exp_b <= 0;
      wc <= 0;
      wp <= 0;
      fa <= 0;
      fb <= 0;
      st_exp <= 0;
    end else begin
      // status is registered one cycle before the master takes it
      wp <= wc == WIN - 1;
      wc <= wc == WIN - 1 ? 0 : wc + 1;
      if (wp) begin
        fa <= rate_bad(cfg_a, T1_KHZ);
        fb <= rate_bad(cfg_b, E1_KHZ);
      end
      st_exp <= fa | (fb << 1) | (((cfg_a & 31) >= NUM_CH) << 2) | (((cfg_b & 31) >= NUM_CH) << 3);
      exp_a <= src(cfg_a, recov, ext_a);
      exp_b <= src(cfg_b, recov, ext_b);
      if (I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_BYTEENABLE[0]) begin
        if (I_AVS_ADDRESS == REF_A_OFS) cfg_a <= int'(I_AVS_WRITEDATA[6:0]);
        if (I_AVS_ADDRESS == REF_B_OFS) cfg_b <= int'(I_AVS_WRITEDATA[6:0]);
      end
    end
  end
  // pins: reference output only meaningful while driven
  always @(negedge I_CLK) begin
    if (go) begin
      chk_pin(O_REF_A_OE, cfg_a[6]);
      chk_pin(O_REF_B_OE, cfg_b[6]);
      if (cfg_a[6]) chk_pin(O_REF_A, exp_a[0]);
      if (cfg_b[6]) chk_pin(O_REF_B, exp_b[0]);
    end
  end
  initial begin
    repeat (3) @(posedge I_CLK);
    I_RESET <= 1'b0;
    go <= 1'b1;
    bus(1'b0, REF_A_OFS, 8'h00, 4'hF);
    bus(1'b0, REF_B_OFS, 8'h00, 4'hF);
    for (int k = 0; k < 64; k++) begin
      bus(1'b1, k[5] ? REF_B_OFS : REF_A_OFS, {3'($random(seed)), 5'(k)}, 4'h1);
      bus(1'b0, k[5] ? REF_B_OFS : REF_A_OFS, 8'h00, 4'hF);
    end
    bus(1'b1, REF_A_OFS, 8'hFF, 4'hE);
    bus(1'b0, REF_A_OFS, 8'h00, 4'hF);
    bus(1'b1, 10'h3FC, 8'h55, 4'h1);
    bus(1'b0, 10'h3FC, 8'h00, 4'hF);
    bus(1'b1, REF_A_OFS, 8'h41, 4'h1);
    bus(1'b1, REF_B_OFS, 8'h7D, 4'h1);
    repeat (2 * WIN + 100) @(posedge I_CLK);
    bus(1'b0, STATUS_OFS, 8'h00, 4'hF);
    bus(1'b1, REF_A_OFS, 8'h61, 4'h1);
    bus(1'b1, REF_B_OFS, 8'h5D, 4'h1);
    repeat (2 * WIN + 100) @(posedge I_CLK);
    bus(1'b0, STATUS_OFS, 8'h00, 4'hF);
    @(posedge I_CLK);
    I_RESET <= 1'b1;
    repeat (3) @(posedge I_CLK);
    I_RESET <= 1'b0;
    bus(1'b0, REF_A_OFS, 8'h00, 4'hF);
    bus(1'b0, REF_B_OFS, 8'h00, 4'hF);
    repeat (5) @(posedge I_CLK);
    summarize;
  end
endmodule // test_reference_clock_output_selector
